// *** bdmm_data_memory_map.sv ***
// Purpose: banked 8-bit data memory map: core registers, peripheral window, RAM, indirect ports
// Assumes: APB slave, data address index = paddr[13:2], one byte per aligned word
// Notes: the peripheral window and the configuration-bank window are forwarded out, not held here
// Operation
// - offsets 0Ch..1Fh of each bank form the peripheral control window
// - banks 27, 28, 29 route that window to pin-select/logic-cell config instead
// - each bank holds up to 80 bytes of general RAM at 20h..6Fh
// - all general RAM forms one linear region reachable through the pointers
// - offsets 70h..7Fh hit the same 16 common bytes in every bank
// - indirect ports access the address held in their pointer pair
// - program-counter latch holds 7 bits, top bit reads zero, resets zero
// - 12-bit data address: upper five bits bank, lower seven offset
// - twelve core registers sit at offsets 00h..0Bh of every bank
// - unimplemented locations read as zero
`timescale 1ns/1ps
`include "bdmm_defines.svh"

module bdmm_data_memory_map #(
    parameter int RAM_BANKS = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic softRst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic periphSel,
    output logic cfgSel,
    output logic periphWrite,
    output logic [11:0] periphAddr,
    output logic [7:0] periphWdata,
    input wire logic [7:0] periphRdata,
    output logic [4:0] bankSel,
    output logic [7:0] workingAcc,
    output logic [7:0] pcLow,
    output logic [6:0] pcLatchHigh,
    output logic globalIntAllow,
    output logic periphIntAllow,
    output logic extEdgeSelect
);
    localparam int RAM_DEPTH = `BDMM_COMMON_BYTES + `BDMM_RAM_PER_BANK * RAM_BANKS;
    localparam int IDX_W = $clog2(RAM_DEPTH);
    localparam logic [15:0] LINEAR_BYTES = 16'(`BDMM_RAM_PER_BANK * RAM_BANKS);

    if (RAM_BANKS < 1 || RAM_BANKS > `BDMM_BANK_COUNT) begin : g_bad_banks
        $error("bdmm_data_memory_map: RAM_BANKS must be 1 to 32");
    end

    bdmm_pkg::bdmm_core_t st;
    bdmm_pkg::bdmm_core_t next_st;
    bdmm_pkg::bdmm_region_t region;

    logic [11:0] wordIdx;
    logic [6:0] dirOff;
    logic busBad;
    logic isPort;
    logic [15:0] ptr;
    logic linear;
    logic effOk;
    logic [11:0] effAddr;
    logic [6:0] effOff;
    logic [4:0] effBank;
    logic [IDX_W-1:0] ramIdx;
    logic [7:0] rdByte;
    logic wrNow;
    logic rdNow;

    bdmm_ram_if #(.IDX_W(IDX_W)) ramBus ();

    // ======================================================================
    // helper functions

    // byte store index of a banked RAM or common RAM location
    function automatic logic [IDX_W-1:0] ramIndex(input logic [4:0] bank, input logic [6:0] off);
        int unsigned v;
        v = 0;
        if (off >= `BDMM_COMMON_FIRST) begin
            v = int'(off) - int'(`BDMM_COMMON_FIRST);
        end else begin
            v = `BDMM_COMMON_BYTES + int'(bank) * `BDMM_RAM_PER_BANK
                + int'(off) - int'(`BDMM_RAM_FIRST);
        end
        return v[IDX_W-1:0];
    endfunction

    // value seen when a core register is read
    function automatic logic [7:0] coreRead(input logic [6:0] off, input bdmm_pkg::bdmm_core_t s);
        logic [7:0] v;
        v = 8'h00;
        case (off)
            `BDMM_OFS_PCLOW: v = s.pcLow;
            `BDMM_OFS_STATUS: v = {3'h0, s.status[4:0]};
            `BDMM_OFS_P0LOW: v = s.ptr0Low;
            `BDMM_OFS_P0HIGH: v = s.ptr0High;
            `BDMM_OFS_P1LOW: v = s.ptr1Low;
            `BDMM_OFS_P1HIGH: v = s.ptr1High;
            `BDMM_OFS_BANKSEL: v = {3'h0, s.bankSel};
            `BDMM_OFS_WORKING: v = s.working;
            `BDMM_OFS_LATCHHI: v = {1'b0, s.latchHigh};
            `BDMM_OFS_INTCTL: v = s.intCtl;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // ======================================================================
    // bus address split and indirect resolution
    assign wordIdx = paddr[13:2];
    assign dirOff = wordIdx[6:0];
    // upper bits or a byte offset inside the word fall outside the map
    assign busBad = (paddr[15:14] != 2'h0) || (paddr[1:0] != 2'h0);
    assign isPort = (dirOff == `BDMM_OFS_PORT0) || (dirOff == `BDMM_OFS_PORT1);
    assign ptr = (dirOff == `BDMM_OFS_PORT1) ? {st.ptr1High, st.ptr1Low}
                                              : {st.ptr0High, st.ptr0Low};

    // ports are not storage: they redirect to the pointer target
    always_comb begin
        linear = 1'b0;
        effOk = 1'b1;
        effAddr = wordIdx;
        if (isPort) begin
            if (ptr < `BDMM_DIRECT_LIMIT) begin
                effAddr = ptr[11:0];
            end else if (ptr[15:13] == `BDMM_LINEAR_TAG && {3'h0, ptr[12:0]} < LINEAR_BYTES) begin
                linear = 1'b1;
            end else begin
                effOk = 1'b0;
            end
        end
    end

    assign effOff = effAddr[6:0];
    assign effBank = effAddr[11:7];

    // ======================================================================
    // region decode of the effective address
    always_comb begin
        region = bdmm_pkg::BDMM_NONE;
        ramIdx = '0;
        if (busBad || !effOk) begin
            region = bdmm_pkg::BDMM_NONE;
        end else if (linear) begin
            // linear space is laid out in the store exactly as bank after bank
            region = bdmm_pkg::BDMM_RAM;
            ramIdx = IDX_W'(`BDMM_COMMON_BYTES + int'(ptr[12:0]));
        end else if (effOff < `BDMM_CORE_COUNT) begin
            // a pointer aimed at a port would recurse, so it reads zero instead
            if (isPort && effOff <= `BDMM_OFS_PORT1) begin
                region = bdmm_pkg::BDMM_NONE;
            end else begin
                region = bdmm_pkg::BDMM_CORE;
            end
        end else if (effOff <= `BDMM_WIN_LAST) begin
            if (effBank >= `BDMM_CFG_BANK_FIRST && effBank <= `BDMM_CFG_BANK_LAST) begin
                region = bdmm_pkg::BDMM_CFG;
            end else begin
                region = bdmm_pkg::BDMM_WINDOW;
            end
        end else if (effOff < `BDMM_COMMON_FIRST) begin
            if (int'(effBank) < RAM_BANKS) begin
                region = bdmm_pkg::BDMM_RAM;
                ramIdx = ramIndex(effBank, effOff);
            end
        end else begin
            region = bdmm_pkg::BDMM_RAM;
            ramIdx = ramIndex(effBank, effOff);
        end
    end

    // ======================================================================
    // transfer phases: read sampled in setup, write taken in access
    assign rdNow = psel && !penable && !pwrite;
    assign wrNow = psel && penable && pwrite && pstrb[0] && !busBad;

    // read byte source; anything unmapped gives zero
    always_comb begin
        case (region)
            bdmm_pkg::BDMM_CORE: rdByte = coreRead(effOff, st);
            bdmm_pkg::BDMM_WINDOW: rdByte = periphRdata;
            bdmm_pkg::BDMM_CFG: rdByte = periphRdata;
            bdmm_pkg::BDMM_RAM: rdByte = ramBus.rdata;
            default: rdByte = 8'h00;
        endcase
    end

    // ======================================================================
    // byte store and forwarded peripheral bus
    assign ramBus.idx = ramIdx;
    assign ramBus.we = wrNow && region == bdmm_pkg::BDMM_RAM;
    assign ramBus.wdata = pwdata[7:0];

    bdmm_ram_store #(
        .DEPTH(RAM_DEPTH),
        .IDX_W(IDX_W)
    ) u_store (
        .clk(clk),
        .rst(rst),
        .ram(ramBus)
    );

    // window and config strobes stand for the whole transfer
    assign periphSel = psel && region == bdmm_pkg::BDMM_WINDOW;
    assign cfgSel = psel && region == bdmm_pkg::BDMM_CFG;
    assign periphWrite = wrNow && (periphSel || cfgSel);
    assign periphAddr = effAddr;
    assign periphWdata = pwdata[7:0];

    // ======================================================================
    // core register updates
    always_comb begin
        next_st = st;
        if (rdNow) begin
            next_st.rdByte = rdByte;
        end
        if (wrNow && region == bdmm_pkg::BDMM_CORE) begin
            case (effOff)
                `BDMM_OFS_PCLOW: next_st.pcLow = pwdata[7:0];
                // only the ALU flags are writable, reset flags are read only
                `BDMM_OFS_STATUS: next_st.status = (st.status & ~`BDMM_STATUS_WR_MASK)
                                                   | (pwdata[7:0] & `BDMM_STATUS_WR_MASK);
                `BDMM_OFS_P0LOW: next_st.ptr0Low = pwdata[7:0];
                `BDMM_OFS_P0HIGH: next_st.ptr0High = pwdata[7:0];
                `BDMM_OFS_P1LOW: next_st.ptr1Low = pwdata[7:0];
                `BDMM_OFS_P1HIGH: next_st.ptr1High = pwdata[7:0];
                `BDMM_OFS_BANKSEL: next_st.bankSel = pwdata[4:0];
                `BDMM_OFS_WORKING: next_st.working = pwdata[7:0];
                `BDMM_OFS_LATCHHI: next_st.latchHigh = pwdata[6:0];
                `BDMM_OFS_INTCTL: next_st.intCtl = pwdata[7:0] & `BDMM_INTCTL_WR_MASK;
                default: next_st = next_st;
            endcase
        end
        // soft reset wins over a same-cycle write; working and low pointers hold
        if (softRst) begin
            next_st.pcLow = `BDMM_RST_PCLOW;
            next_st.working = st.working;
            next_st.ptr0Low = st.ptr0Low;
            next_st.ptr1Low = st.ptr1Low;
            next_st.status = st.status;
            next_st.ptr0High = `BDMM_RST_PTR;
            next_st.ptr1High = `BDMM_RST_PTR;
            next_st.bankSel = `BDMM_RST_BANKSEL;
            next_st.latchHigh = `BDMM_RST_LATCHHI;
            next_st.intCtl = `BDMM_RST_INTCTL;
        end
    end

    // power-on reset loads every core register
    always_ff @(posedge clk) begin
        if (rst) begin
            st.pcLow <= `BDMM_RST_PCLOW;
            st.status <= `BDMM_RST_STATUS;
            st.ptr0Low <= `BDMM_RST_PTR;
            st.ptr0High <= `BDMM_RST_PTR;
            st.ptr1Low <= `BDMM_RST_PTR;
            st.ptr1High <= `BDMM_RST_PTR;
            st.bankSel <= `BDMM_RST_BANKSEL;
            st.working <= `BDMM_RST_WORKING;
            st.latchHigh <= `BDMM_RST_LATCHHI;
            st.intCtl <= `BDMM_RST_INTCTL;
            st.rdByte <= 8'h00;
        end else begin
            st <= next_st;
        end
    end

    // ======================================================================
    // outputs
    assign pready = penable; // one access cycle, no wait states
    assign pslverr = psel && penable && busBad;
    assign prdata = {24'h000000, st.rdByte};
    assign bankSel = st.bankSel;
    assign workingAcc = st.working;
    assign pcLow = st.pcLow;
    assign pcLatchHigh = st.latchHigh;
    assign globalIntAllow = st.intCtl[`BDMM_INT_GLOBAL];
    assign periphIntAllow = st.intCtl[`BDMM_INT_PERIPH];
    assign extEdgeSelect = st.intCtl[`BDMM_INT_EDGE];

    // ======================================================================
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_WINDOW_MAP: assert property (
        psel && !busBad && !isPort && dirOff >= `BDMM_CORE_COUNT && dirOff <= `BDMM_WIN_LAST
        && !(wordIdx[11:7] >= `BDMM_CFG_BANK_FIRST && wordIdx[11:7] <= `BDMM_CFG_BANK_LAST)
        |-> periphSel && !cfgSel && periphAddr == wordIdx)
        else $error("window offset did not select the peripheral window");

    AST_CFG_BANKS: assert property (
        psel && !busBad && !isPort && dirOff >= `BDMM_CORE_COUNT && dirOff <= `BDMM_WIN_LAST
        && wordIdx[11:7] >= `BDMM_CFG_BANK_FIRST && wordIdx[11:7] <= `BDMM_CFG_BANK_LAST
        |-> cfgSel && !periphSel)
        else $error("config bank window went to the peripheral window");

    AST_RAM_SPAN: assert property (
        rdNow && !busBad && !isPort && dirOff >= `BDMM_RAM_FIRST && dirOff < `BDMM_COMMON_FIRST
        && int'(wordIdx[11:7]) >= RAM_BANKS
        |=> prdata == 32'h00000000)
        else $error("general RAM beyond the fitted banks did not read zero");

    AST_LINEAR: assert property (
        psel && !busBad && linear
        |-> region == bdmm_pkg::BDMM_RAM
        && ramIdx == ramIndex(5'(int'(ptr[12:0]) / `BDMM_RAM_PER_BANK),
                              7'(int'(`BDMM_RAM_FIRST) + int'(ptr[12:0]) % `BDMM_RAM_PER_BANK)))
        else $error("linear pointer did not reach the matching banked RAM byte");

    AST_COMMON: assert property (
        psel && !busBad && !isPort && dirOff >= `BDMM_COMMON_FIRST
        |-> region == bdmm_pkg::BDMM_RAM && ramIdx == IDX_W'(dirOff - `BDMM_COMMON_FIRST))
        else $error("common RAM index depends on the bank");

    AST_INDIRECT: assert property (
        wrNow && dirOff == `BDMM_OFS_PORT0 && {st.ptr0High, st.ptr0Low} == 16'h0009 && !softRst
        |=> workingAcc == $past(pwdata[7:0]) && st.ptr0Low == 8'h09)
        else $error("indirect write missed its pointer target");

    AST_LATCH_READ: assert property (
        rdNow && !busBad && !isPort && dirOff == `BDMM_OFS_LATCHHI
        |=> prdata[7] == 1'b0 && prdata[6:0] == $past(pcLatchHigh))
        else $error("program counter latch read is wrong");

    AST_CORE_MIRROR: assert property (
        wrNow && !isPort && dirOff == `BDMM_OFS_BANKSEL && !softRst
        |=> bankSel == $past(pwdata[4:0]) ##1 ($past(softRst) || bankSel == $past(bankSel)))
        else $error("bank selector not reachable from this bank");

    AST_UNMAPPED: assert property (
        rdNow && busBad ##1 penable && psel |-> prdata == 32'h00000000 && pslverr)
        else $error("unmapped read did not return zero with error");

    AST_SOFT_RESET: assert property (
        softRst |=> workingAcc == $past(workingAcc) && st.ptr0Low == $past(st.ptr0Low)
        && bankSel == `BDMM_RST_BANKSEL && !globalIntAllow && extEdgeSelect)
        else $error("soft reset did not keep or load the core registers");
endmodule

// *** bdmm_defines.svh ***
// Purpose: constants of the banked data memory map: offsets, fields, reset values, bounds
// Assumes: included by bare name from every file that needs a figure
// Notes: offsets are positions within a 128-location bank; the APB byte address is 4x the index
`ifndef BDMM_DEFINES_SVH
`define BDMM_DEFINES_SVH

// ==========================================================================
// core register offsets, mirrored in every bank
`define BDMM_OFS_PORT0 7'h00
`define BDMM_OFS_PORT1 7'h01
`define BDMM_OFS_PCLOW 7'h02
`define BDMM_OFS_STATUS 7'h03
`define BDMM_OFS_P0LOW 7'h04
`define BDMM_OFS_P0HIGH 7'h05
`define BDMM_OFS_P1LOW 7'h06
`define BDMM_OFS_P1HIGH 7'h07
`define BDMM_OFS_BANKSEL 7'h08
`define BDMM_OFS_WORKING 7'h09
`define BDMM_OFS_LATCHHI 7'h0A
`define BDMM_OFS_INTCTL 7'h0B

// ==========================================================================
// bank layout
`define BDMM_CORE_COUNT 7'h0C
`define BDMM_WIN_LAST 7'h1F
`define BDMM_RAM_FIRST 7'h20
`define BDMM_COMMON_FIRST 7'h70
`define BDMM_RAM_PER_BANK 32'h50
`define BDMM_COMMON_BYTES 32'h10
`define BDMM_CFG_BANK_FIRST 5'h1B
`define BDMM_CFG_BANK_LAST 5'h1D
`define BDMM_BANK_COUNT 32'h20
`define BDMM_LINEAR_TAG 3'h1
`define BDMM_DIRECT_LIMIT 16'h1000

// ==========================================================================
// field positions and write masks
`define BDMM_INT_GLOBAL 7
`define BDMM_INT_PERIPH 6
`define BDMM_INT_EDGE 0
`define BDMM_STATUS_WR_MASK 8'h07
`define BDMM_INTCTL_WR_MASK 8'hC1

// ==========================================================================
// reset values
`define BDMM_RST_PCLOW 8'h00
`define BDMM_RST_STATUS 8'h18
`define BDMM_RST_PTR 8'h00
`define BDMM_RST_BANKSEL 5'h00
`define BDMM_RST_WORKING 8'h00
`define BDMM_RST_LATCHHI 7'h00
`define BDMM_RST_INTCTL 8'h01

`endif

// *** bdmm_pkg.sv ***
// Purpose: shared types of the banked data memory map
// Assumes: constants live in bdmm_defines.svh
// Notes: none
package bdmm_pkg;

    // ======================================================================
    // where a decoded data address lands
    typedef enum logic [2:0] {
        BDMM_CORE,
        BDMM_WINDOW,
        BDMM_CFG,
        BDMM_RAM,
        BDMM_NONE
    } bdmm_region_t;

    // ======================================================================
    // whole state of the core register file
    typedef struct packed {
        logic [7:0] pcLow;
        logic [7:0] status;
        logic [7:0] ptr0Low;
        logic [7:0] ptr0High;
        logic [7:0] ptr1Low;
        logic [7:0] ptr1High;
        logic [4:0] bankSel;
        logic [7:0] working;
        logic [6:0] latchHigh;
        logic [7:0] intCtl;
        logic [7:0] rdByte;
    } bdmm_core_t;

endpackage

// *** bdmm_ram_if.sv ***
// Purpose: carrier between the map decoder and the byte store
// Assumes: single port, read is combinational on idx, write on the clock edge
// Notes: none
`timescale 1ns/1ps

interface bdmm_ram_if #(
    parameter int IDX_W = 12
);
    logic [IDX_W-1:0] idx;
    logic we;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport ctrl (output idx, output we, output wdata, input rdata);
    modport store (input idx, input we, input wdata, output rdata);
endinterface

// *** bdmm_ram_store.sv ***
// Purpose: flip-flop byte store for common RAM and the general RAM of the fitted banks
// Assumes: index 0..15 is common RAM, then 80 bytes per bank in bank order
// Notes: cleared on power-on reset only, so contents survive soft resets
`timescale 1ns/1ps
`include "bdmm_defines.svh"

module bdmm_ram_store #(
    parameter int DEPTH = 2576,
    parameter int IDX_W = 12
) (
    input wire logic clk,
    input wire logic rst,
    bdmm_ram_if.store ram
);
    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
    } bdmm_store_t;

    bdmm_store_t st;
    bdmm_store_t next_st;

    if (DEPTH < 1 || DEPTH > (1 << IDX_W)) begin : g_bad_depth
        $error("bdmm_ram_store: DEPTH does not fit the index width");
    end

    // ======================================================================
    // read is combinational; out-of-range indexes read zero
    assign ram.rdata = (int'(ram.idx) < DEPTH) ? st.mem[ram.idx] : 8'h00;

    // write one byte
    always_comb begin
        next_st = st;
        if (ram.we && int'(ram.idx) < DEPTH) begin
            next_st.mem[ram.idx] = ram.wdata;
        end
    end

    // register the copy
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// *** bdmm_periph_model.sv ***
// Purpose: stand-in for the peripheral and configuration registers behind the window pins
// Assumes: periphRdata must settle combinationally from periphAddr in the setup cycle
// Notes: one copy per kind of window, so a byte written in one bank shows in all banks of that kind
`timescale 1ns/1ps

module bdmm_periph_model (
    input wire logic clk,
    input wire logic periphSel,
    input wire logic cfgSel,
    input wire logic periphWrite,
    input wire logic [11:0] periphAddr,
    input wire logic [7:0] periphWdata,
    output logic [7:0] periphRdata
);
    logic [7:0] regs [64];
    logic [7:0] lastRd;
    logic [5:0] slot;

    // ======================================================================
    // storage, keyed by window kind and offset 0Ch..1Fh
    assign slot = {cfgSel, periphAddr[4:0]};
    initial begin
        lastRd = 8'h00;
        for (int i = 0; i < 64; i++) begin
            regs[i] = 8'h00;
        end
    end
    always @(posedge clk) begin
        if (periphWrite) begin
            regs[slot] <= periphWdata;
        end
        if (periphSel || cfgSel) begin
            lastRd <= regs[slot];
        end
    end
    // unselected: inverse of the last answer, so a stale byte can never pass
    assign periphRdata = (periphSel || cfgSel) ? regs[slot] : ~lastRd;
endmodule

// *** bdmm_data_memory_map_tb.sv ***
// Purpose: self-checking bench of the banked data memory map over APB
// Assumes: two banks of general RAM to keep the flop store small
// Notes: expected bytes follow from the map layout, never from the design
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin failures++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end

module bdmm_data_memory_map_tb;
    logic clk, rst, softRst, psel, penable, pwrite, pready, pslverr;
    logic periphSel, cfgSel, periphWrite, globalIntAllow, periphIntAllow, extEdgeSelect;
    logic sawErr, sawPeriph, sawCfg;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [11:0] periphAddr;
    logic [7:0] periphWdata, periphRdata, workingAcc, pcLow, rd;
    logic [4:0] bankSel;
    logic [6:0] pcLatchHigh;
    logic [7:0] rstVal [12] = '{8'h00, 8'h00, 8'h00, 8'h18, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h01};
    int failures, cmpCount;

    bdmm_data_memory_map #(.RAM_BANKS(2)) DUT (.clk(clk), .rst(rst), .softRst(softRst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .periphSel(periphSel), .cfgSel(cfgSel), .periphWrite(periphWrite),
        .periphAddr(periphAddr), .periphWdata(periphWdata), .periphRdata(periphRdata),
        .bankSel(bankSel), .workingAcc(workingAcc), .pcLow(pcLow), .pcLatchHigh(pcLatchHigh),
        .globalIntAllow(globalIntAllow), .periphIntAllow(periphIntAllow),
        .extEdgeSelect(extEdgeSelect));
    bdmm_periph_model p (.clk(clk), .periphSel(periphSel), .cfgSel(cfgSel),
        .periphWrite(periphWrite), .periphAddr(periphAddr), .periphWdata(periphWdata),
        .periphRdata(periphRdata));

    // ======================================================================
    // clock and closing report
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmpCount, failures);
        if (failures == 0 && cmpCount > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ======================================================================
    // bus tasks: one transfer, a write, a read with its expected byte
    task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] wd,
        input logic [3:0] strb);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, wd};
        pstrb <= strb;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // bounded wait, the slave sets the pace
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            summarize();
        end
        rd = prdata[7:0];
        sawErr = pslverr;
        sawPeriph = periphSel;
        sawCfg = cfgSel;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] b, input logic [6:0] o, input logic [7:0] d);
        apb(1'b1, {2'h0, b, o, 2'h0}, d, 4'h1);
    endtask
    task automatic rdc(input logic [4:0] b, input logic [6:0] o, input logic [7:0] e);
        apb(1'b0, {2'h0, b, o, 2'h0}, 8'h00, 4'h1);
        `CHK("read byte", e, rd)
        `CHK("upper lanes", 24'h000000, prdata[31:8])
    endtask

    // ======================================================================
    // main sequence
    initial begin
        rst = 1'b1;
        softRst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h00000000;
        pstrb = 4'h0;
        failures = 0;
        cmpCount = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // core registers read through a far bank right after power-on
        for (int i = 0; i < 12; i++) begin
            rdc(5'h09, i[6:0], rstVal[i]);
        end
        // pointer 0 direct 009h: a port write lands in the working register
        wr(5'h00, 7'h04, 8'h09);
        wr(5'h03, 7'h00, 8'h5C);
        rdc(5'h00, 7'h09, 8'h5C);
        wr(5'h05, 7'h09, 8'hA5);
        rdc(5'h00, 7'h09, 8'hA5);
        `CHK("working pin", 8'hA5, workingAcc)
        wr(5'h00, 7'h02, 8'h44);
        rdc(5'h06, 7'h02, 8'h44);
        wr(5'h00, 7'h0A, 8'hFF);
        rdc(5'h03, 7'h0A, 8'h7F);
        `CHK("latch pin", 7'h7F, pcLatchHigh)
        wr(5'h00, 7'h03, 8'hFF);
        rdc(5'h00, 7'h03, 8'h1F);
        wr(5'h00, 7'h0B, 8'hFF);
        rdc(5'h00, 7'h0B, 8'hC1);
        `CHK("window flag at 0Bh", 1'b0, sawPeriph)
        `CHK("allow pins", 3'h7, {globalIntAllow, periphIntAllow, extEdgeSelect})
        wr(5'h00, 7'h08, 8'hFF);
        rdc(5'h1F, 7'h08, 8'h1F);
        `CHK("bank pin", 5'h1F, bankSel)
        // common RAM at both ends of its range, seen from other banks
        wr(5'h00, 7'h70, 8'h3C);
        wr(5'h03, 7'h7F, 8'hC3);
        rdc(5'h1E, 7'h70, 8'h3C);
        rdc(5'h00, 7'h7F, 8'hC3);
        // general RAM edges, other bank untouched, missing bank reads zero
        wr(5'h01, 7'h20, 8'h5A);
        wr(5'h01, 7'h6F, 8'h6B);
        wr(5'h04, 7'h20, 8'h99);
        rdc(5'h01, 7'h20, 8'h5A);
        rdc(5'h01, 7'h6F, 8'h6B);
        rdc(5'h00, 7'h20, 8'h00);
        rdc(5'h04, 7'h20, 8'h00);
        // pointer 0 linear 209Fh is bank 1 offset 6Fh; pointer 1 direct 0A0h
        wr(5'h00, 7'h04, 8'h9F);
        wr(5'h00, 7'h05, 8'h20);
        rdc(5'h02, 7'h00, 8'h6B);
        wr(5'h07, 7'h00, 8'h11);
        rdc(5'h01, 7'h6F, 8'h11);
        wr(5'h00, 7'h06, 8'hA0);
        wr(5'h00, 7'h07, 8'h00);
        rdc(5'h00, 7'h01, 8'h5A);
        // window forwarded out; banks 27..29 go to the configuration side
        wr(5'h00, 7'h0D, 8'h77);
        rdc(5'h1A, 7'h0D, 8'h77);
        `CHK("window flag", 1'b1, sawPeriph)
        `CHK("config flag bank 26", 1'b0, sawCfg)
        rdc(5'h1B, 7'h0D, 8'h00);
        `CHK("config flag", 1'b1, sawCfg)
        wr(5'h1D, 7'h1F, 8'h33);
        rdc(5'h1C, 7'h1F, 8'h33);
        rdc(5'h00, 7'h1F, 8'h00);
        // refused accesses: no strobe, then a misaligned read
        apb(1'b1, {2'h0, 5'h00, 7'h09, 2'h0}, 8'h55, 4'h0);
        rdc(5'h00, 7'h09, 8'hA5);
        apb(1'b0, {2'h0, 5'h00, 7'h09, 2'h1}, 8'h00, 4'h1);
        `CHK("misaligned error", 1'b1, sawErr)
        `CHK("misaligned data", 8'h00, rd)
        // soft reset keeps working, low pointers, status and RAM
        @(posedge clk);
        softRst <= 1'b1;
        @(posedge clk);
        softRst <= 1'b0;
        rdc(5'h00, 7'h09, 8'hA5);
        rdc(5'h00, 7'h04, 8'h9F);
        rdc(5'h00, 7'h05, 8'h00);
        rdc(5'h00, 7'h06, 8'hA0);
        rdc(5'h00, 7'h08, 8'h00);
        rdc(5'h00, 7'h02, 8'h00);
        rdc(5'h00, 7'h0A, 8'h00);
        rdc(5'h00, 7'h0B, 8'h01);
        rdc(5'h00, 7'h03, 8'h1F);
        rdc(5'h01, 7'h20, 8'h5A);
        // power-on reset loads every reset value again, status back to 18h
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc(5'h00, 7'h09, 8'h00);
        rdc(5'h00, 7'h03, 8'h18);
        `CHK("pc low pin", 8'h00, pcLow)
        summarize();
    end
endmodule
